// ---- icsr_regs.sv ----
// Page-0 control and status register bank of the inertial unit.
// Assumes byte writes and word reads from the host access port, event
// pulses from the sensor core, and configuration levels from page 1.
`default_nettype none
`include "icsr_consts.svh"
module icsr_regs (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire icsr_pkg::icsr_wr_req_t wrReq,
  input wire icsr_pkg::icsr_rd_req_t rdReq,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic burstStart,
  output logic [1:0] modeRequest,
  input wire logic modeSwitchDone,
  output logic modeStatus,
  input wire icsr_pkg::icsr_fault_ev_t faultEv,
  input wire icsr_pkg::icsr_cfg_t cfg,
  input wire logic [12:0] freshSet,
  input wire logic [6:0] limitSet,
  input wire logic sampleReadySignal,
  input wire logic [1:0] auxIn,
  output logic [1:0] auxOut,
  output logic [1:0] auxOe,
  output logic extInputLevel
);
  import icsr_pkg::*;

  // Channel whose upper word is read at the given address
  function automatic logic [12:0] chanHit(input logic [6:0] a);
    logic [12:0] m;
    m = 13'h0000;
    m[12] = (a == `ICSR_RD_TEMP);
    m[11] = (a == `ICSR_RD_XGYR);
    m[10] = (a == `ICSR_RD_YGYR);
    m[9] = (a == `ICSR_RD_ZGYR);
    m[8] = (a == `ICSR_RD_XACC);
    m[7] = (a == `ICSR_RD_YACC);
    m[6] = (a == `ICSR_RD_ZACC);
    m[5] = (a == `ICSR_RD_XANG);
    m[4] = (a == `ICSR_RD_YANG);
    m[3] = (a == `ICSR_RD_ZANG);
    m[2] = (a == `ICSR_RD_XVEL);
    m[1] = (a == `ICSR_RD_YVEL);
    m[0] = (a == `ICSR_RD_ZVEL);
    return m;
  endfunction

  // Diagnostic word with combined self-test bit
  function automatic logic [15:0] diagWord(input icsr_diag_t d);
    icsr_diag_t w;
    w = d;
    w.rsvd15 = 1'b0;
    w.rsvd7 = 1'b0;
    w.stAny = |d.selftest;
    return w;
  endfunction

  // Registered state and its next values
  icsr_mode_state_t modeState, next_modeState;
  logic [1:0] modeCmd, next_modeCmd;
  logic modeStat, next_modeStat;
  logic burstPulse, next_burstPulse;
  icsr_diag_t diag, next_diag;
  logic [12:0] fresh, next_fresh;
  logic [6:0] limit, next_limit;
  logic [1:0] auxDir, next_auxDir;
  logic [1:0] auxLevel, next_auxLevel;
  logic [15:0] rdWord, next_rdWord;
  logic rdStb, next_rdStb;
  logic [1:0] pinOut, next_pinOut;
  logic [1:0] pinOe, next_pinOe;
  logic extLevel, next_extLevel;

  // Decoded address and summaries
  logic [6:0] rdAddr;
  logic [15:0] diagNow;
  logic anyFault;
  logic limitAny;
  logic [1:0] auxGpio;
  logic [1:0] auxRead;

  always_comb begin
    rdAddr = {rdReq.addr[6:1], 1'b0};
    diagNow = diagWord(diag);
    anyFault = |diagNow;
    limitAny = |limit;
    auxGpio[0] = ~cfg.readyPinEnable;
    auxGpio[1] = (cfg.extSel == `ICSR_EXT_GPIO);
    auxRead = (auxDir & auxLevel) | (~auxDir & auxIn);
  end

  // Burst trigger and mode command
  always_comb begin
    next_burstPulse = 1'b0;
    next_modeState = modeState;
    next_modeCmd = modeCmd;
    next_modeStat = modeStat;
    if (wrReq.wr && wrReq.addr == `ICSR_OFF_BURST &&
        wrReq.data == `ICSR_BURST_CODE) begin
      next_burstPulse = 1'b1;
    end
    case (modeState)
      MODE_IDLE: begin
        // Unused codes are dropped, status bit is never written
        if (wrReq.wr && wrReq.addr == `ICSR_OFF_MODE_HI &&
            (wrReq.data[1:0] == `ICSR_CMD_SAMPLE ||
             wrReq.data[1:0] == `ICSR_CMD_CONFIG)) begin
          next_modeCmd = wrReq.data[1:0];
          next_modeState = MODE_BUSY;
        end
      end
      MODE_BUSY: begin
        if (modeSwitchDone) begin
          next_modeStat = (modeCmd == `ICSR_CMD_CONFIG);
          next_modeCmd = `ICSR_CMD_NONE;
          next_modeState = MODE_IDLE;
        end
      end
      default: begin
        next_modeState = MODE_IDLE;
        next_modeCmd = `ICSR_CMD_NONE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeState <= MODE_IDLE;
      modeCmd <= `ICSR_CMD_NONE;
      modeStat <= `ICSR_MODE_STAT_RST;
      burstPulse <= 1'b0;
    end else begin
      modeState <= next_modeState;
      modeCmd <= next_modeCmd;
      modeStat <= next_modeStat;
      burstPulse <= next_burstPulse;
    end
  end

  // Fault, fresh-sample and limit flags; a set wins over a read clear
  always_comb begin
    next_diag = diag;
    next_fresh = fresh;
    next_limit = limit;
    if (rdReq.rd && rdAddr == `ICSR_OFF_DIAG) begin
      next_diag = '0;
    end
    if (rdReq.rd) begin
      next_fresh = fresh & ~chanHit(rdReq.addr);
    end
    if (rdReq.rd && rdAddr == `ICSR_OFF_LIMIT) begin
      next_limit = 7'h00;
    end
    next_fresh = next_fresh | freshSet;
    next_limit = next_limit | limitSet;
    if (faultEv.selftestDone) begin
      next_diag.selftest = faultEv.selftestFail;
    end
    if (!cfg.deltaEnable && (cfg.rateFilterInvalid ||
        (cfg.orientSel == `ICSR_ORIENT_ON &&
         cfg.extSel == `ICSR_EXT_TRIGGER))) begin
      next_diag.setErr = 1'b1;
    end
    if (faultEv.angOvf) begin
      next_diag.angOvf = 1'b1;
    end
    if (faultEv.velOvf) begin
      next_diag.velOvf = 1'b1;
    end
    if (faultEv.hwCheckDone) begin
      next_diag.hwFault = faultEv.hwFault;
    end
    if (faultEv.serOvr) begin
      next_diag.serOvr = 1'b1;
    end
    if (faultEv.asyncOvr) begin
      next_diag.asyncOvr = 1'b1;
    end
    if (faultEv.nvTestDone && faultEv.nvTestFail) begin
      next_diag.nvTest = 1'b1;
    end
    if (faultEv.nvSaveDone && faultEv.nvSaveFail) begin
      next_diag.nvSave = 1'b1;
    end
    next_diag.rsvd15 = 1'b0;
    next_diag.rsvd7 = 1'b0;
    next_diag.stAny = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      diag <= '0;
      fresh <= 13'h0000;
      limit <= 7'h00;
    end else begin
      diag <= next_diag;
      fresh <= next_fresh;
      limit <= next_limit;
    end
  end

  // Aux pin port, pin drive and read data
  always_comb begin
    next_auxDir = auxDir;
    next_auxLevel = auxLevel;
    if (wrReq.wr && wrReq.addr == `ICSR_OFF_AUX) begin
      next_auxDir = wrReq.data[1:0];
    end
    if (wrReq.wr && wrReq.addr == `ICSR_OFF_AUX_HI) begin
      next_auxLevel = wrReq.data[1:0];
    end
    // Pin one carries data-ready when enabled
    next_pinOe[0] = cfg.readyPinEnable | (auxGpio[0] & next_auxDir[0]);
    next_pinOut[0] = cfg.readyPinEnable ? sampleReadySignal
                                        : next_auxLevel[0];
    next_pinOe[1] = auxGpio[1] & next_auxDir[1];
    next_pinOut[1] = next_auxLevel[1];
    next_extLevel = auxIn[1];
    // Read word registered one cycle after the request
    next_rdStb = rdReq.rd;
    next_rdWord = `ICSR_WORD_ZERO;
    if (rdReq.rd) begin
      case (rdAddr)
        `ICSR_OFF_MODE: begin
          next_rdWord[`ICSR_MODE_STAT_BIT] = modeStat;
          next_rdWord[9:8] = modeCmd;
        end
        `ICSR_OFF_DIAG: begin
          next_rdWord = diagNow;
        end
        `ICSR_OFF_FLAG: begin
          next_rdWord = {fresh[12:6], limitAny, fresh[5:0], 1'b0, anyFault};
        end
        `ICSR_OFF_AUX: begin
          next_rdWord = {6'h00, auxRead, 6'h00, auxDir};
        end
        `ICSR_OFF_LIMIT: begin
          next_rdWord = {2'h0, limit[6:1], 7'h00, limit[0]};
        end
        default: begin
          next_rdWord = `ICSR_WORD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      auxDir <= 2'h0;
      auxLevel <= 2'h0;
      pinOe <= 2'h0;
      pinOut <= 2'h0;
      extLevel <= 1'b0;
      rdStb <= 1'b0;
      rdWord <= `ICSR_WORD_ZERO;
    end else begin
      auxDir <= next_auxDir;
      auxLevel <= next_auxLevel;
      pinOe <= next_pinOe;
      pinOut <= next_pinOut;
      extLevel <= next_extLevel;
      rdStb <= next_rdStb;
      rdWord <= next_rdWord;
    end
  end

  // Ports straight from registers
  always_comb begin
    rdData = rdWord;
    rdValid = rdStb;
    burstStart = burstPulse;
    modeRequest = modeCmd;
    modeStatus = modeStat;
    auxOut = pinOut;
    auxOe = pinOe;
    extInputLevel = extLevel;
  end
endmodule
`default_nettype wire

// ---- icsr_consts.svh ----
// Offsets, field positions and reset values of the control/status bank.
// Assumes byte addresses of page 0 as seen by the host access port.
`ifndef ICSR_CONSTS_SVH
`define ICSR_CONSTS_SVH

`define ICSR_OFF_BURST 7'h00
`define ICSR_OFF_MODE_HI 7'h03
`define ICSR_OFF_MODE 7'h02
`define ICSR_OFF_DIAG 7'h04
`define ICSR_OFF_FLAG 7'h06
`define ICSR_OFF_AUX 7'h08
`define ICSR_OFF_AUX_HI 7'h09
`define ICSR_OFF_LIMIT 7'h0c

`define ICSR_BURST_CODE 8'h00
`define ICSR_CMD_NONE 2'h0
`define ICSR_CMD_SAMPLE 2'h1
`define ICSR_CMD_CONFIG 2'h2
`define ICSR_MODE_STAT_BIT 10
`define ICSR_MODE_STAT_RST 1'b1
`define ICSR_ORIENT_ON 2'h2
`define ICSR_EXT_TRIGGER 2'h3
`define ICSR_EXT_GPIO 2'h0

`define ICSR_RD_TEMP 7'h0e
`define ICSR_RD_XGYR 7'h12
`define ICSR_RD_YGYR 7'h16
`define ICSR_RD_ZGYR 7'h1a
`define ICSR_RD_XACC 7'h1e
`define ICSR_RD_YACC 7'h22
`define ICSR_RD_ZACC 7'h26
`define ICSR_RD_XANG 7'h64
`define ICSR_RD_YANG 7'h68
`define ICSR_RD_ZANG 7'h6c
`define ICSR_RD_XVEL 7'h70
`define ICSR_RD_YVEL 7'h74
`define ICSR_RD_ZVEL 7'h78

`define ICSR_WORD_ZERO 16'h0000

`endif

// ---- icsr_pkg.sv ----
// Types shared by the control/status bank and its surroundings.
// Assumes icsr_consts.svh for all numeric values.
`default_nettype none
package icsr_pkg;
  typedef enum logic {MODE_IDLE, MODE_BUSY} icsr_mode_state_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic wr;
  } icsr_wr_req_t;

  typedef struct packed {
    logic [6:0] addr;
    logic rd;
  } icsr_rd_req_t;

  // Stored fault bits in register layout; bit 1 is formed on read
  typedef struct packed {
    logic rsvd15;
    logic [3:0] selftest;
    logic setErr;
    logic angOvf;
    logic velOvf;
    logic rsvd7;
    logic [1:0] hwFault;
    logic serOvr;
    logic asyncOvr;
    logic nvTest;
    logic stAny;
    logic nvSave;
  } icsr_diag_t;

  typedef struct packed {
    logic selftestDone;
    logic [3:0] selftestFail;
    logic angOvf;
    logic velOvf;
    logic hwCheckDone;
    logic [1:0] hwFault;
    logic serOvr;
    logic asyncOvr;
    logic nvTestDone;
    logic nvTestFail;
    logic nvSaveDone;
    logic nvSaveFail;
  } icsr_fault_ev_t;

  typedef struct packed {
    logic deltaEnable;
    logic rateFilterInvalid;
    logic [1:0] orientSel;
    logic [1:0] extSel;
    logic readyPinEnable;
  } icsr_cfg_t;
endpackage
`default_nettype wire

// ---- icsr_host_model.sv ----
// Host model: byte writes and word reads into the register bank.
// Assumes the bank answers a read one cycle after taking it.
`default_nettype none
`include "icsr_consts.svh"
module icsr_host_model (
  input wire logic ref_clk,
  input wire logic [15:0] rdData,
  output var icsr_pkg::icsr_wr_req_t wrReq,
  output var icsr_pkg::icsr_rd_req_t rdReq
);
  timeunit 1ns;
  timeprecision 1ps;
  import icsr_pkg::*;
  initial begin
    wrReq = '0;
    rdReq = '0;
  end
  // Released lines show the inverse of the last value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 wrReq = '{addr: a, data: d, wr: 1'b1};
    @(posedge ref_clk);
    #1 wrReq = '{addr: ~a, data: ~d, wr: 1'b0};
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    @(posedge ref_clk);
    #1 rdReq = '{addr: a, rd: 1'b1};
    @(posedge ref_clk);
    #1 rdReq = '{addr: ~a, rd: 1'b0};
    q = rdData;
  endtask
  // Only the two defined mode codes
  task automatic mode(input logic toConfig);
    wr(`ICSR_OFF_MODE_HI, toConfig ? 8'h02 : 8'h01);
  endtask
endmodule
`default_nettype wire

// ---- icsr_regs_chk.sv ----
// Assertions on the register bank ports.
// Assumes a bind onto every bank instance.
`default_nettype none
`include "icsr_consts.svh"
module icsr_regs_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire icsr_pkg::icsr_wr_req_t wrReq,
  input wire icsr_pkg::icsr_rd_req_t rdReq,
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  input wire logic burstStart,
  input wire logic [1:0] modeRequest,
  input wire logic modeSwitchDone,
  input wire logic modeStatus,
  input wire icsr_pkg::icsr_fault_ev_t faultEv,
  input wire icsr_pkg::icsr_cfg_t cfg,
  input wire logic sampleReadySignal,
  input wire logic [1:0] auxOut,
  input wire logic [1:0] auxOe
);
  timeunit 1ns;
  timeprecision 1ps;
  import icsr_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic rdDiag;
  logic quiet;
  logic modeWr;
  assign rdDiag = rdReq.rd && rdReq.addr[6:1] == 6'h02;
  assign quiet = faultEv == '0 && (cfg.deltaEnable || !cfg.rateFilterInvalid
    && !(cfg.orientSel == `ICSR_ORIENT_ON && cfg.extSel == `ICSR_EXT_TRIGGER));
  assign modeWr = wrReq.wr && wrReq.addr == `ICSR_OFF_MODE_HI;
  property p_burst;
    wrReq.wr && wrReq.addr == `ICSR_OFF_BURST && wrReq.data == 8'h00
      |=> burstStart;
  endproperty
  a_burst: assert property (p_burst) else $error("no burst");
  property p_mode_take;
    modeWr && wrReq.data[1:0] == `ICSR_CMD_SAMPLE
      && modeRequest == `ICSR_CMD_NONE |=> modeRequest == `ICSR_CMD_SAMPLE;
  endproperty
  a_mode_take: assert property (p_mode_take) else $error("mode cmd");
  property p_mode_done;
    modeRequest != `ICSR_CMD_NONE && modeSwitchDone
      |=> modeRequest == `ICSR_CMD_NONE && modeStatus == $past(modeRequest[1]);
  endproperty
  a_mode_done: assert property (p_mode_done) else $error("mode end");
  property p_mode_hold;
    modeRequest == `ICSR_CMD_NONE |=> $stable(modeStatus);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("status");
  property p_diag_clr;
    rdDiag && quiet ##1 quiet ##1 rdDiag && quiet |=> rdData == 16'h0000;
  endproperty
  a_diag_clr: assert property (p_diag_clr) else $error("diag clr");
  property p_st_any;
    rdValid && $past(rdReq.addr[6:1]) == 6'h02
      |-> rdData[1] == |rdData[14:11];
  endproperty
  a_st_any: assert property (p_st_any) else $error("st any");
  property p_ready_pin;
    cfg.readyPinEnable |=> auxOe[0] && auxOut[0] == $past(sampleReadySignal);
  endproperty
  a_ready_pin: assert property (p_ready_pin) else $error("pin one");
  property p_ext_pin;
    cfg.extSel != `ICSR_EXT_GPIO |=> !auxOe[1];
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("pin two");
endmodule
bind icsr_regs icsr_regs_chk chk (.ref_clk, .sys_rst, .wrReq, .rdReq,
  .rdData, .rdValid, .burstStart, .modeRequest, .modeSwitchDone,
  .modeStatus, .faultEv, .cfg, .sampleReadySignal, .auxOut, .auxOe);
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the control/status bank.
// Assumes the host model drives the register port.
`default_nettype none
`include "icsr_consts.svh"
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) begin \
      bad_count++; \
      $display("ERROR %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import icsr_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  icsr_wr_req_t wrReq;
  icsr_rd_req_t rdReq;
  icsr_fault_ev_t faultEv;
  icsr_fault_ev_t ev;
  icsr_cfg_t cfg;
  logic [15:0] rdData, q, r, e;
  logic rdValid, burstStart, modeSwitchDone, modeStatus, extInputLevel;
  logic sampleReadySignal;
  logic [1:0] modeRequest, auxIn, auxOut, auxOe;
  logic [12:0] freshSet, m;
  logic [6:0] limitSet;
  logic [31:0] seed = 32'h0000_ed41;
  int bad_count = 0;
  int num_checks = 0;
  logic [6:0] chan [13] = '{`ICSR_RD_TEMP, `ICSR_RD_XGYR, `ICSR_RD_YGYR,
    `ICSR_RD_ZGYR, `ICSR_RD_XACC, `ICSR_RD_YACC, `ICSR_RD_ZACC, `ICSR_RD_XANG,
    `ICSR_RD_YANG, `ICSR_RD_ZANG, `ICSR_RD_XVEL, `ICSR_RD_YVEL, `ICSR_RD_ZVEL};
  icsr_regs dut (.ref_clk, .sys_rst, .wrReq, .rdReq, .rdData, .rdValid,
    .burstStart, .modeRequest, .modeSwitchDone, .modeStatus, .faultEv, .cfg,
    .freshSet, .limitSet, .sampleReadySignal, .auxIn, .auxOut, .auxOe,
    .extInputLevel);
  icsr_host_model host (.ref_clk, .rdData, .wrReq, .rdReq);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) #1 sampleReadySignal = seed[3];
  function automatic logic [15:0] diag_exp(input icsr_fault_ev_t v);
    return {1'b0, v.selftestFail, 1'b0, v.angOvf, v.velOvf, 1'b0, v.hwFault,
      v.serOvr, v.asyncOvr, v.nvTestFail, |v.selftestFail, v.nvSaveFail};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic draw();
    repeat (16) seed = lfsr(seed);
    r = seed[15:0];
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    finish_test();
  end
  initial begin
    faultEv = '0;
    cfg = '0;
    freshSet = '0;
    limitSet = '0;
    modeSwitchDone = 1'b0;
    auxIn = 2'b00;
    repeat (10) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    `CHK(modeStatus, 1'b1)
    host.wr(`ICSR_OFF_BURST, 8'h5a);
    `CHK(burstStart, 1'b0)
    host.wr(`ICSR_OFF_BURST, `ICSR_BURST_CODE);
    `CHK(burstStart, 1'b1)
    for (int i = 0; i < 2; i++) begin
      host.mode(i == 1);
      host.wr(`ICSR_OFF_MODE_HI, 8'h03);
      `CHK(modeRequest, i ? `ICSR_CMD_CONFIG : `ICSR_CMD_SAMPLE)
      tick();
      modeSwitchDone = 1'b1;
      tick();
      modeSwitchDone = 1'b0;
      `CHK({modeStatus, modeRequest}, {i == 1, 2'b00})
      host.rd(`ICSR_OFF_MODE, q);
      `CHK(q[10:8], {i == 1, 2'b00})
      host.wr(`ICSR_OFF_MODE_HI, 8'h07);
      `CHK({modeStatus, modeRequest}, {i == 1, 2'b00})
    end
    for (int i = 0; i < 12; i++) begin
      draw();
      ev = i ? r : 16'h0000;
      ev.selftestFail &= {4{ev.selftestDone}};
      ev.hwFault &= {2{ev.hwCheckDone}};
      ev.nvTestFail &= ev.nvTestDone;
      ev.nvSaveFail &= ev.nvSaveDone;
      tick();
      faultEv = ev;
      tick();
      faultEv = '0;
      e = diag_exp(ev);
      host.rd(`ICSR_OFF_FLAG, q);
      `CHK(q[0], |e)
      host.wr(`ICSR_OFF_DIAG, 8'hff);
      host.rd(`ICSR_OFF_DIAG, q);
      `CHK(q, e)
      host.rd(`ICSR_OFF_DIAG, q);
      `CHK(q, 16'h0000)
      host.rd(`ICSR_OFF_FLAG, q);
      `CHK(q[0], 1'b0)
    end
    for (int i = 0; i < 3; i++) begin
      cfg.deltaEnable = (i == 2);
      cfg.rateFilterInvalid = (i != 1);
      cfg.orientSel = `ICSR_ORIENT_ON;
      cfg.extSel = (i == 1) ? `ICSR_EXT_TRIGGER : `ICSR_EXT_GPIO;
      tick();
      tick();
      cfg = '0;
      host.rd(`ICSR_OFF_DIAG, q);
      `CHK(q[10], i != 2)
    end
    freshSet = 13'h1fff;
    limitSet = 7'h08;
    tick();
    freshSet = '0;
    limitSet = '0;
    m = 13'h1fff;
    host.rd(`ICSR_OFF_FLAG, q);
    `CHK(q, 16'hfffc)
    for (int i = 0; i < 13; i++) begin
      host.rd(chan[i], q);
      m[12 - i] = 1'b0;
      host.rd(`ICSR_OFF_FLAG, q);
      `CHK(q, {m[12:6], 1'b1, m[5:0], 2'b00})
    end
    host.rd(`ICSR_OFF_LIMIT, q);
    `CHK(q, 16'h0400)
    host.rd(`ICSR_OFF_FLAG, q);
    `CHK(q[8], 1'b0)
    for (int i = 0; i < 16; i++) begin
      draw();
      auxIn = r[5:4];
      host.wr(`ICSR_OFF_AUX, {6'h00, r[1:0]});
      host.wr(`ICSR_OFF_AUX_HI, {6'h00, r[3:2]});
      `CHK(auxOe, r[1:0])
      `CHK(auxOut & r[1:0], r[3:2] & r[1:0])
      host.rd(`ICSR_OFF_AUX, q);
      `CHK(q[9:8], (r[3:2] & r[1:0]) | (r[5:4] & ~r[1:0]))
      `CHK(rdValid, 1'b1)
      `CHK(extInputLevel, r[5])
    end
    cfg.readyPinEnable = 1'b1;
    cfg.extSel = 2'h1;
    tick();
    tick();
    `CHK(auxOe, 2'b01)
    for (int i = 0; i < 4; i++) begin
      draw();
      tick();
      tick();
      `CHK(auxOut[0], seed[3])
    end
    host.wr(7'h40, 8'hff);
    host.rd(7'h40, q);
    `CHK(q, 16'h0000)
    finish_test();
  end
endmodule
`default_nettype wire
